// ### logic/clp_pkg.sv
package clp_pkg;

  // Detection modes
  typedef enum logic [1:0] {
    CLP_MODE_BKR = 2'h0,
    CLP_MODE_UC  = 2'h1,
    CLP_MODE_AND = 2'h2,
    CLP_MODE_OR  = 2'h3
  } clp_mode_t;

  // Supervisor states, Gray along warm -> delay -> cold -> inrush -> settle
  typedef enum logic [2:0] {
    CLP_ST_WARM   = 3'h0,
    CLP_ST_DELAY  = 3'h1,
    CLP_ST_COLD   = 3'h3,
    CLP_ST_INRUSH = 3'h2,
    CLP_ST_SETTLE = 3'h6
  } clp_state_t;

  localparam int CLP_CUR_W = 16;
  localparam int CLP_TIME_W = 16;
  localparam int CLP_PRE_W = 16;
  localparam int CLP_INT_W = 4;

  // Timer unit: 1 ms at 20 MHz
  localparam int CLP_CLK_HZ = 20000000;
  localparam int CLP_TICK_US = 1000;
  localparam logic [CLP_PRE_W-1:0] CLP_TICK_CYC =
    CLP_PRE_W'(CLP_CLK_HZ / 1000000 * CLP_TICK_US);

  // Hysteresis 90 percent as 9/10
  localparam int CLP_HYST_NUM = 9;
  localparam int CLP_HYST_DEN = 10;

  // Register offsets
  localparam logic [3:0] CLP_REG_CTRL = 4'h0;
  localparam logic [3:0] CLP_REG_UC_THR = 4'h1;
  localparam logic [3:0] CLP_REG_IR_THR = 4'h2;
  localparam logic [3:0] CLP_REG_T_OFF = 4'h3;
  localparam logic [3:0] CLP_REG_T_SETTLE = 4'h4;
  localparam logic [3:0] CLP_REG_T_MAX = 4'h5;
  localparam logic [3:0] CLP_REG_STATUS = 4'h6;
  localparam logic [3:0] CLP_REG_INT_STAT = 4'h7;
  localparam logic [3:0] CLP_REG_INT_EN = 4'h8;
  localparam logic [3:0] CLP_REG_INT_CLR = 4'h9;

  // Control fields
  localparam int CLP_CTRL_ENA_BIT = 0;
  localparam int CLP_CTRL_MODE_LSB = 1;
  localparam int CLP_CTRL_BLK_SEL_BIT = 3;
  localparam int CLP_CTRL_AR_PRES_BIT = 4;

  // Interrupt bits
  localparam int CLP_INT_COLD = 0;
  localparam int CLP_INT_END = 1;
  localparam int CLP_INT_MAXBLK = 2;
  localparam int CLP_INT_BLOCK = 3;

  // Reset values
  localparam logic [15:0] CLP_CTRL_RST = 16'h0001;
  localparam logic [CLP_CUR_W-1:0] CLP_UC_THR_RST = 16'h0010;
  localparam logic [CLP_CUR_W-1:0] CLP_IR_THR_RST = 16'h0800;
  localparam logic [CLP_TIME_W-1:0] CLP_T_OFF_RST = 16'h0064;
  localparam logic [CLP_TIME_W-1:0] CLP_T_SETTLE_RST = 16'h0064;
  localparam logic [CLP_TIME_W-1:0] CLP_T_MAX_RST = 16'h03E8;

endpackage

// ### logic/clp_tick.sv
`timescale 1ns/1ps
module clp_tick (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Tick
  output logic tick
);

  logic [clp_pkg::CLP_PRE_W-1:0] cnt_q;
  logic [clp_pkg::CLP_PRE_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 16'h0001;
    if (cnt_q == clp_pkg::CLP_TICK_CYC - 16'h0001)
    begin
      cnt_d = 16'h0000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// ### logic/clp_sync.sv
`timescale 1ns/1ps
module clp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  assign dout = s2_q;

endmodule

// ### logic/clp_cold_load.sv
// Overview of operation
// - Warm-to-cold is detected by breaker open, undercurrent, their AND or their OR, per mode.
// - Detecting cold load starts the load-off delay timer.
// - When the load-off delay expires the cold load enable output is raised.
// - When the cold condition ends, inrush supervision begins.
// - Inrush is present while a phase current rises above the inrush threshold.
// - Inrush is finished once all currents fall to 90 percent of that threshold.
// - A finished inrush starts the settle timer.
// - The enable drops through the inrush path only after the settle timer expires.
// - A maximum-block timer runs from the end of cold load and clears the enable on expiry.
// - The maximum-block timer stops when current stays below 0.9 threshold for the settle time.
// - A selected external or internal block input suppresses the whole function.
// - Where reclosing exists, a running reclose cycle blocks the function.
// - The block gives only the enable indication and never a trip.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module clp_cold_load (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Plant pins
  input wire logic breaker_closed,
  input wire logic [clp_pkg::CLP_CUR_W-1:0] phase_a_cur,
  input wire logic [clp_pkg::CLP_CUR_W-1:0] phase_b_cur,
  input wire logic [clp_pkg::CLP_CUR_W-1:0] phase_c_cur,
  input wire logic ext_block,
  input wire logic int_block,
  input wire logic auto_reclose_running,
  // Indications
  output logic cold_load_enable_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [3*clp_pkg::CLP_CUR_W+3:0] pins_s;
  logic [clp_pkg::CLP_CUR_W-1:0] ia_s;
  logic [clp_pkg::CLP_CUR_W-1:0] ib_s;
  logic [clp_pkg::CLP_CUR_W-1:0] ic_s;
  logic tick;

  // Currents come from a sampled ADC path and are assumed stable across samples
  clp_sync #(.W(3 * clp_pkg::CLP_CUR_W + 4)) u_sync_pins (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din({phase_a_cur, phase_b_cur, phase_c_cur, breaker_closed, ext_block, int_block,
      auto_reclose_running}),
    .dout(pins_s)
  );

  clp_tick u_tick (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  logic brk_closed, ext_blk, int_blk, ar_run;

  assign brk_closed = pins_s[3];
  assign ext_blk = pins_s[2];
  assign int_blk = pins_s[1];
  assign ar_run = pins_s[0];
  assign ic_s = pins_s[4 +: clp_pkg::CLP_CUR_W];
  assign ib_s = pins_s[4 + clp_pkg::CLP_CUR_W +: clp_pkg::CLP_CUR_W];
  assign ia_s = pins_s[4 + 2 * clp_pkg::CLP_CUR_W +: clp_pkg::CLP_CUR_W];

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] uc_thr_q, uc_thr_d;
  logic [15:0] ir_thr_q, ir_thr_d;
  logic [15:0] t_off_q, t_off_d;
  logic [15:0] t_settle_q, t_settle_d;
  logic [15:0] t_max_q, t_max_d;
  logic [3:0] int_en_q, int_en_d;
  logic [3:0] int_stat_q, int_stat_d;
  logic [15:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [3:0] events;
  logic [15:0] status_word;

  always_comb
  begin
    ctrl_d = ctrl_q;
    uc_thr_d = uc_thr_q;
    ir_thr_d = ir_thr_q;
    t_off_d = t_off_q;
    t_settle_d = t_settle_q;
    t_max_d = t_max_q;
    int_en_d = int_en_q;
    int_stat_d = int_stat_q;
    if (reg_wr)
    begin
      case (reg_addr)
        clp_pkg::CLP_REG_CTRL: ctrl_d = {11'h000, reg_wdata[4:0]};
        clp_pkg::CLP_REG_UC_THR: uc_thr_d = reg_wdata;
        clp_pkg::CLP_REG_IR_THR: ir_thr_d = reg_wdata;
        clp_pkg::CLP_REG_T_OFF: t_off_d = reg_wdata;
        clp_pkg::CLP_REG_T_SETTLE: t_settle_d = reg_wdata;
        clp_pkg::CLP_REG_T_MAX: t_max_d = reg_wdata;
        clp_pkg::CLP_REG_INT_EN: int_en_d = reg_wdata[3:0];
        clp_pkg::CLP_REG_INT_CLR: int_stat_d = int_stat_q & ~reg_wdata[3:0];
        default: ;
      endcase
    end
    // Set beats a clear in the same cycle
    int_stat_d = int_stat_d | events;
    irq_d = |(int_stat_d & int_en_d);
    rdata_d = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        clp_pkg::CLP_REG_CTRL: rdata_d = ctrl_q;
        clp_pkg::CLP_REG_UC_THR: rdata_d = uc_thr_q;
        clp_pkg::CLP_REG_IR_THR: rdata_d = ir_thr_q;
        clp_pkg::CLP_REG_T_OFF: rdata_d = t_off_q;
        clp_pkg::CLP_REG_T_SETTLE: rdata_d = t_settle_q;
        clp_pkg::CLP_REG_T_MAX: rdata_d = t_max_q;
        clp_pkg::CLP_REG_STATUS: rdata_d = status_word;
        clp_pkg::CLP_REG_INT_STAT: rdata_d = {12'h000, int_stat_q};
        clp_pkg::CLP_REG_INT_EN: rdata_d = {12'h000, int_en_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= clp_pkg::CLP_CTRL_RST;
      uc_thr_q <= clp_pkg::CLP_UC_THR_RST;
      ir_thr_q <= clp_pkg::CLP_IR_THR_RST;
      t_off_q <= clp_pkg::CLP_T_OFF_RST;
      t_settle_q <= clp_pkg::CLP_T_SETTLE_RST;
      t_max_q <= clp_pkg::CLP_T_MAX_RST;
      int_en_q <= 4'h0;
      int_stat_q <= 4'h0;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      uc_thr_q <= uc_thr_d;
      ir_thr_q <= ir_thr_d;
      t_off_q <= t_off_d;
      t_settle_q <= t_settle_d;
      t_max_q <= t_max_d;
      int_en_q <= int_en_d;
      int_stat_q <= int_stat_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Current comparators

  // Scaled compare: cur*10 against thr*9, avoids a divider
  function automatic logic below_hyst(input logic [15:0] cur, input logic [15:0] thr);
    logic [19:0] lhs;
    logic [19:0] rhs;
    lhs = 20'(cur) * 20'(clp_pkg::CLP_HYST_DEN);
    rhs = 20'(thr) * 20'(clp_pkg::CLP_HYST_NUM);
    return lhs <= rhs;
  endfunction

  logic fn_enabled;
  logic blocked;
  logic undercur;
  logic above_ir;
  logic all_low;
  logic cold_cond;
  clp_pkg::clp_mode_t mode;

  assign mode = clp_pkg::clp_mode_t'(ctrl_q[clp_pkg::CLP_CTRL_MODE_LSB +: 2]);
  assign fn_enabled = ctrl_q[clp_pkg::CLP_CTRL_ENA_BIT];

  assign undercur = (ia_s < uc_thr_q) && (ib_s < uc_thr_q) && (ic_s < uc_thr_q);
  assign above_ir = (ia_s > ir_thr_q) || (ib_s > ir_thr_q) || (ic_s > ir_thr_q);
  assign all_low = below_hyst(ia_s, ir_thr_q) && below_hyst(ib_s, ir_thr_q)
    && below_hyst(ic_s, ir_thr_q);

  assign blocked = !fn_enabled
    || (ctrl_q[clp_pkg::CLP_CTRL_BLK_SEL_BIT] ? int_blk : ext_blk)
    || (ctrl_q[clp_pkg::CLP_CTRL_AR_PRES_BIT] && ar_run);

  always_comb
  begin
    case (mode)
      clp_pkg::CLP_MODE_BKR: cold_cond = !brk_closed;
      clp_pkg::CLP_MODE_UC: cold_cond = undercur;
      clp_pkg::CLP_MODE_AND: cold_cond = !brk_closed && undercur;
      clp_pkg::CLP_MODE_OR: cold_cond = !brk_closed || undercur;
      default: cold_cond = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Supervisor state machine

  clp_pkg::clp_state_t st_q, st_d;
  logic [15:0] tmr_q, tmr_d;
  logic [15:0] max_q, max_d;
  logic max_run_q, max_run_d;
  logic en_q, en_d;
  logic blk_q, blk_d;

  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q;
    max_d = max_q;
    max_run_d = max_run_q;
    en_d = en_q;
    events = 4'h0;
    blk_d = blocked;
    if (blocked && !blk_q)
    begin
      events[clp_pkg::CLP_INT_BLOCK] = 1'b1;
    end
    if (tick && tmr_q != 16'h0000)
    begin
      tmr_d = tmr_q - 16'h0001;
    end
    if (tick && max_run_q && max_q != 16'h0000)
    begin
      max_d = max_q - 16'h0001;
    end
    if (blocked)
    begin
      st_d = clp_pkg::CLP_ST_WARM;
      en_d = 1'b0;
      max_run_d = 1'b0;
      tmr_d = 16'h0000;
    end
    else
    begin
      case (st_q)
        clp_pkg::CLP_ST_WARM:
        begin
          if (cold_cond)
          begin
            st_d = clp_pkg::CLP_ST_DELAY;
            tmr_d = t_off_q;
          end
        end
        clp_pkg::CLP_ST_DELAY:
        begin
          if (!cold_cond)
          begin
            st_d = clp_pkg::CLP_ST_WARM;
          end
          else if (tmr_q == 16'h0000)
          begin
            st_d = clp_pkg::CLP_ST_COLD;
            en_d = 1'b1;
            events[clp_pkg::CLP_INT_COLD] = 1'b1;
          end
        end
        clp_pkg::CLP_ST_COLD:
        begin
          if (!cold_cond)
          begin
            st_d = clp_pkg::CLP_ST_INRUSH;
            max_d = t_max_q;
            max_run_d = 1'b1;
          end
        end
        clp_pkg::CLP_ST_INRUSH:
        begin
          if (all_low && !above_ir)
          begin
            st_d = clp_pkg::CLP_ST_SETTLE;
            tmr_d = t_settle_q;
          end
        end
        clp_pkg::CLP_ST_SETTLE:
        begin
          if (!all_low)
          begin
            st_d = clp_pkg::CLP_ST_INRUSH;
          end
          else if (tmr_q == 16'h0000)
          begin
            st_d = clp_pkg::CLP_ST_WARM;
            en_d = 1'b0;
            max_run_d = 1'b0;
            events[clp_pkg::CLP_INT_END] = 1'b1;
          end
        end
        default: st_d = clp_pkg::CLP_ST_WARM;
      endcase
      if (max_run_q && max_q == 16'h0000 && st_d != clp_pkg::CLP_ST_WARM)
      begin
        st_d = clp_pkg::CLP_ST_WARM;
        en_d = 1'b0;
        max_run_d = 1'b0;
        events[clp_pkg::CLP_INT_MAXBLK] = 1'b1;
      end
      // Cold again keeps the enable, unless it has just been released
      if (cold_cond && st_d != clp_pkg::CLP_ST_WARM
        && (st_q == clp_pkg::CLP_ST_INRUSH || st_q == clp_pkg::CLP_ST_SETTLE))
      begin
        st_d = clp_pkg::CLP_ST_COLD;
        max_run_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= clp_pkg::CLP_ST_WARM;
      tmr_q <= 16'h0000;
      max_q <= 16'h0000;
      max_run_q <= 1'b0;
      en_q <= 1'b0;
      blk_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      max_q <= max_d;
      max_run_q <= max_run_d;
      en_q <= en_d;
      blk_q <= blk_d;
    end
  end

  assign status_word = {6'h00, st_q, max_run_q, blocked, all_low, above_ir, undercur,
    brk_closed, en_q};

  assign cold_load_enable_out = en_q;
  assign irq = irq_q;

endmodule

// ### verification/clp_plant_model.sv
`timescale 1ns/1ps
module clp_plant_model #(
  parameter int OP_DLY = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Bench commands
  input wire logic cmd_closed,
  input wire logic [15:0] cmd_a,
  input wire logic [15:0] cmd_b,
  input wire logic [15:0] cmd_c,
  // Breaker contact and measured currents
  output logic breaker_closed,
  output logic [15:0] phase_a_cur,
  output logic [15:0] phase_b_cur,
  output logic [15:0] phase_c_cur
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic pos_d;
  ////////////////////////////////////////////////////////////
  // Contact moves only after the mechanism time, never at once
  always_comb
  begin
    cnt_d = (cmd_closed == breaker_closed) ? 8'h00 : cnt_q + 8'h01;
    pos_d = (cnt_q == 8'(OP_DLY)) ? cmd_closed : breaker_closed;
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= 8'h00;
      breaker_closed <= 1'b1;
      phase_a_cur <= 16'h0000;
      phase_b_cur <= 16'h0000;
      phase_c_cur <= 16'h0000;
    end
    else
    begin
      cnt_q <= cnt_d;
      breaker_closed <= pos_d;
      phase_a_cur <= cmd_a;
      phase_b_cur <= cmd_b;
      phase_c_cur <= cmd_c;
    end
  end
endmodule

// ### verification/clp_cold_load_properties.sv
`timescale 1ns/1ps
module clp_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Plant pins
  input wire logic breaker_closed,
  input wire logic [15:0] phase_a_cur,
  input wire logic [15:0] phase_b_cur,
  input wire logic [15:0] phase_c_cur,
  input wire logic ext_block,
  input wire logic int_block,
  input wire logic auto_reclose_running,
  // Indications
  input wire logic cold_load_enable_out,
  input wire logic irq
);
  logic [4:0] ctrl_q;
  logic [4:0] ctrl_d;
  logic [3:0] ien_q;
  logic [3:0] ien_d;
  logic [4:0] pin1_q;
  logic [4:0] pin2_q;
  logic uc;
  logic cold;
  logic blk;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // Threshold not shadowed: bench keeps its reset value
  // Pins judged two flops late, as the block sees them
  always_comb
  begin
    ctrl_d = (reg_wr && reg_addr == clp_pkg::CLP_REG_CTRL) ? reg_wdata[4:0] : ctrl_q;
    ien_d = (reg_wr && reg_addr == clp_pkg::CLP_REG_INT_EN) ? reg_wdata[3:0] : ien_q;
    uc = phase_a_cur < clp_pkg::CLP_UC_THR_RST && phase_b_cur < clp_pkg::CLP_UC_THR_RST
      && phase_c_cur < clp_pkg::CLP_UC_THR_RST;
    cold = ctrl_q[2] ? (ctrl_q[1] ? (!pin2_q[4] || pin2_q[3]) : (!pin2_q[4] && pin2_q[3]))
      : (ctrl_q[1] ? pin2_q[3] : !pin2_q[4]);
    blk = !ctrl_q[0] || (ctrl_q[3] ? pin2_q[1] : pin2_q[2]) || (ctrl_q[4] && pin2_q[0]);
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= clp_pkg::CLP_CTRL_RST[4:0];
      ien_q <= 4'h0;
      pin1_q <= 5'h00;
      pin2_q <= 5'h00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
      pin1_q <= {breaker_closed, uc, ext_block, int_block, auto_reclose_running};
      pin2_q <= pin1_q;
    end
  end
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside a read cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h9 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_clear_reads_zero: assert property (reg_rd && reg_addr == clp_pkg::CLP_REG_INT_CLR
    |=> reg_rdata == 16'h0000) else $error("clear register read not zero");
  a_block_drops_en: assert property (blk [*6] |-> !cold_load_enable_out)
    else $error("enable held while blocked");
  a_no_rise_blocked: assert property ($rose(cold_load_enable_out) |-> !$past(blk))
    else $error("enable rose while blocked");
  a_en_needs_cold: assert property ($rose(cold_load_enable_out) |-> $past(cold))
    else $error("enable rose without cold condition");
  a_mask_quiet: assert property ((ien_q == 4'h0) [*2] |-> !irq)
    else $error("interrupt with all sources masked");
  a_irq_on_cold: assert property ($rose(cold_load_enable_out) && ien_q[0] |-> ##[0:3] irq)
    else $error("no interrupt on enable rise");
  a_irq_on_end: assert property ($fell(cold_load_enable_out) && !$past(blk)
    && ien_q[2:1] == 2'b11 |-> ##[0:3] irq) else $error("no interrupt on enable end");
endmodule
bind clp_cold_load clp_checker clp_checker_inst (.core_clk, .reset_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .breaker_closed, .phase_a_cur, .phase_b_cur, .phase_c_cur,
  .ext_block, .int_block, .auto_reclose_running, .cold_load_enable_out, .irq);

// ### verification/tb_cold_load_pickup_logic.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("unexpected at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module tb_cold_load_pickup_logic;
  localparam logic [15:0] W = 16'h0100;
  localparam logic [15:0] L = 16'h0005;
  typedef struct {
    logic [1:0] mode;
    logic closed;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic en;
  } clp_row_t;
  typedef struct {
    logic [15:0] ctrl;
    logic ext;
    logic ib;
    logic ar;
    logic en;
  } clp_blk_t;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic ext_block = 1'b0;
  logic int_block = 1'b0;
  logic auto_reclose_running = 1'b0;
  logic cmd_closed = 1'b1;
  logic [15:0] cmd_a = W;
  logic [15:0] cmd_b = W;
  logic [15:0] cmd_c = W;
  logic breaker_closed;
  logic [15:0] phase_a_cur;
  logic [15:0] phase_b_cur;
  logic [15:0] phase_c_cur;
  logic cold_load_enable_out;
  logic irq;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  // Mode, breaker, three currents, expected enable
  clp_row_t rows [11] = '{'{2'h0, 1'b0, W, W, W, 1'b1}, '{2'h0, 1'b1, L, L, L, 1'b0},
    '{2'h1, 1'b1, L, L, L, 1'b1}, '{2'h1, 1'b0, L, L, W, 1'b0}, '{2'h1, 1'b1, L, W, L, 1'b0},
    '{2'h2, 1'b0, L, L, L, 1'b1}, '{2'h2, 1'b0, W, W, W, 1'b0}, '{2'h2, 1'b1, L, L, L, 1'b0},
    '{2'h3, 1'b0, W, W, W, 1'b1}, '{2'h3, 1'b1, L, L, L, 1'b1}, '{2'h3, 1'b1, W, W, W, 1'b0}};
  // Control word, external, internal, reclose running, expected enable
  clp_blk_t blks [6] = '{'{16'h0001, 1'b1, 1'b0, 1'b0, 1'b0},
    '{16'h0001, 1'b0, 1'b1, 1'b0, 1'b1}, '{16'h0009, 1'b0, 1'b1, 1'b0, 1'b0},
    '{16'h0009, 1'b1, 1'b0, 1'b0, 1'b1}, '{16'h0011, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'h0001, 1'b0, 1'b0, 1'b1, 1'b1}};
  logic [15:0] rstv [6] = '{clp_pkg::CLP_CTRL_RST, clp_pkg::CLP_UC_THR_RST,
    clp_pkg::CLP_IR_THR_RST, clp_pkg::CLP_T_OFF_RST, clp_pkg::CLP_T_SETTLE_RST,
    clp_pkg::CLP_T_MAX_RST};
  clp_cold_load clp_cold_load_inst (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .breaker_closed, .phase_a_cur, .phase_b_cur, .phase_c_cur,
    .ext_block, .int_block, .auto_reclose_running, .cold_load_enable_out, .irq);
  clp_plant_model #(.OP_DLY(4)) clp_plant_model_inst (.core_clk, .reset_n, .cmd_closed,
    .cmd_a, .cmd_b, .cmd_c, .breaker_closed, .phase_a_cur, .phase_b_cur, .phase_c_cur);
  ////////////////////////////////////////////////////////////
  always #25 core_clk = ~core_clk;
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic plant(input logic cl, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] c);
    @(posedge core_clk);
    cmd_closed <= cl;
    cmd_a <= a;
    cmd_b <= b;
    cmd_c <= c;
  endtask
  task automatic blocks(input logic e, input logic i, input logic r);
    @(posedge core_clk);
    ext_block <= e;
    int_block <= i;
    auto_reclose_running <= r;
  endtask
  task automatic wait_en(input logic e, input int n);
    step(1);
    for (int i = 0; i < n && cold_load_enable_out !== e; i++) step(1);
    `CHK(cold_load_enable_out, e)
  endtask
  task automatic wirq(input logic [3:0] a, input logic [15:0] d, input logic e);
    wr(a, d);
    step(2);
    `CHK(irq, e)
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Longest waits are two ticks of the load-off timer and one tick of the max-block timer, plus margin
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 6; k++) rdc(4'(k), rstv[k]);
    wr(4'hF, 16'hFFFF);
    rdc(4'hF, 16'h0000);
    rdc(clp_pkg::CLP_REG_INT_CLR, 16'h0000);
    $display("reset test done");
    wr(clp_pkg::CLP_REG_T_OFF, 16'h0000);
    wr(clp_pkg::CLP_REG_T_SETTLE, 16'h0000);
    foreach (rows[i])
    begin
      wr(clp_pkg::CLP_REG_CTRL, 16'h0000);
      plant(rows[i].closed, rows[i].a, rows[i].b, rows[i].c);
      step(10);
      wr(clp_pkg::CLP_REG_CTRL, {13'h0, rows[i].mode, 1'b1});
      step(30);
      `CHK(cold_load_enable_out, rows[i].en)
    end
    $display("mode table done");
    wr(clp_pkg::CLP_REG_CTRL, 16'h0000);
    plant(1'b1, W, W, W);
    wr(clp_pkg::CLP_REG_T_OFF, 16'h0002);
    wr(clp_pkg::CLP_REG_INT_CLR, 16'h000F);
    wirq(clp_pkg::CLP_REG_INT_EN, 16'h0001, 1'b0);
    wr(clp_pkg::CLP_REG_CTRL, 16'h0001);
    plant(1'b0, W, W, W);
    step(19000);
    `CHK(cold_load_enable_out, 1'b0)
    wait_en(1'b1, 22000);
    step(2);
    `CHK(irq, 1'b1)
    wirq(clp_pkg::CLP_REG_INT_EN, 16'h0000, 1'b0);
    wirq(clp_pkg::CLP_REG_INT_EN, 16'h0001, 1'b1);
    wirq(clp_pkg::CLP_REG_INT_CLR, 16'h0001, 1'b0);
    rdc(clp_pkg::CLP_REG_INT_STAT, 16'h0000);
    $display("load-off delay test done");
    wr(clp_pkg::CLP_REG_INT_EN, 16'h000F);
    wr(clp_pkg::CLP_REG_T_MAX, 16'hFFFF);
    plant(1'b1, 16'h0900, L, L);
    step(100);
    `CHK(cold_load_enable_out, 1'b1)
    plant(1'b1, 16'h0734, L, L);
    step(100);
    `CHK(cold_load_enable_out, 1'b1)
    plant(1'b1, 16'h0733, L, L);
    wait_en(1'b0, 50);
    rdc(clp_pkg::CLP_REG_INT_STAT, 16'h0002);
    $display("settle test done");
    wr(clp_pkg::CLP_REG_T_OFF, 16'h0000);
    wr(clp_pkg::CLP_REG_T_SETTLE, 16'hFFFF);
    wr(clp_pkg::CLP_REG_T_MAX, 16'h0001);
    plant(1'b0, L, L, L);
    wait_en(1'b1, 100);
    wr(clp_pkg::CLP_REG_INT_CLR, 16'h000F);
    plant(1'b1, 16'h0900, 16'h0900, 16'h0900);
    wait_en(1'b0, 42000);
    rdc(clp_pkg::CLP_REG_INT_STAT, 16'h0004);
    $display("max-block test done");
    wr(clp_pkg::CLP_REG_T_SETTLE, 16'h0000);
    plant(1'b0, L, L, L);
    foreach (blks[i])
    begin
      blocks(1'b0, 1'b0, 1'b0);
      wr(clp_pkg::CLP_REG_CTRL, blks[i].ctrl);
      wait_en(1'b1, 100);
      blocks(blks[i].ext, blks[i].ib, blks[i].ar);
      step(20);
      `CHK(cold_load_enable_out, blks[i].en)
    end
    blocks(1'b0, 1'b0, 1'b0);
    $display("block test done");
    summarize();
  end
endmodule
